// ### crg_pkg.sv
// Constants and state type for the coprocessor request/grant relay.
// Assumes one system clock; shared by the relay and its pin synchroniser.
package crg_pkg;
    // Synchroniser depth for the two request/grant pins
    localparam int CRG_SYNC_STAGES = 2;
    // Idle level of a request/grant line: pulses are active low
    localparam logic CRG_LINE_IDLE = 1'b1;
    localparam logic CRG_LINE_DRIVEN = 1'b0;
    // Clocks from a seen grant to the relayed grant, and for a release
    localparam int CRG_GRANT_RELAY_CLKS = 2;
    localparam int CRG_RELEASE_RELAY_CLKS = 1;
    // Dead clocks after each bus exchange
    localparam int CRG_DEAD_CLKS = 1;

    typedef enum logic [2:0] {
        CRG_IDLE,
        CRG_REQ_WAIT,
        CRG_RELAY_GNT,
        CRG_RELAY_HELD,
        CRG_OWN,
        CRG_OWN_WAIT_SLOT,
        CRG_HANDOVER,
        CRG_DEAD
    } crg_state_t;
endpackage

// ### crg_pin_sync.sv
// Two-flop synchroniser for one request/grant pin.
// Assumes the pin is asynchronous to core_clk_in; resets to the idle level.
`timescale 1ns/1ns
module crg_pin_sync
    import crg_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic pin_in,
    output logic pin_sync_out
);
    logic meta_reg;
    logic sync_reg;

    // Reset to idle so an unconnected pin never shows a request
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            meta_reg <= CRG_LINE_IDLE;
            sync_reg <= CRG_LINE_IDLE;
        end
        else
        begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    assign pin_sync_out = sync_reg;
endmodule

// ### crg_relay.sv
// Local bus request/grant relay of a math coprocessor.
// Assumes open-drain request/grant lines with external pull-ups resolved
// by the testbench, and a bus unit reporting its bus states and cycles.
`timescale 1ns/1ns

module crg_relay
    import crg_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic dn_req_grant_in,
    output logic dn_req_grant_out,
    output logic dn_req_grant_oe_out,
    input wire logic up_req_grant_in,
    output logic up_req_grant_out,
    output logic up_req_grant_oe_out,
    input wire logic own_bus_req_in,
    input wire logic own_last_cycle_done_in,
    input wire logic final_bus_state_in,
    input wire logic address_bus_state_in,
    input wire logic hold_ctrl_mode_in,
    output logic bus_owned_out,
    output logic bus_float_out,
    output logic handover_ack_state_out
);
    crg_state_t state_reg;
    logic for_other_reg;
    logic dn_oe_reg;
    logic up_oe_reg;
    logic dn_drv_d1_reg;
    logic dn_drv_d2_reg;
    logic up_drv_d1_reg;
    logic up_drv_d2_reg;
    logic owned_reg;
    logic float_reg;
    logic ack_reg;
    logic dn_sync;
    logic up_sync;
    logic dn_low;
    logic up_low;

    crg_pin_sync u_dn_sync
    (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .pin_in(dn_req_grant_in),
        .pin_sync_out(dn_sync)
    );

    crg_pin_sync u_up_sync
    (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .pin_in(up_req_grant_in),
        .pin_sync_out(up_sync)
    );

    // Our own pulse returns through the synchroniser two clocks later;
    // masking it keeps the device from answering itself
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            dn_drv_d1_reg <= 1'b0;
            dn_drv_d2_reg <= 1'b0;
            up_drv_d1_reg <= 1'b0;
            up_drv_d2_reg <= 1'b0;
        end
        else
        begin
            dn_drv_d1_reg <= dn_oe_reg;
            dn_drv_d2_reg <= dn_drv_d1_reg;
            up_drv_d1_reg <= up_oe_reg;
            up_drv_d2_reg <= up_drv_d1_reg;
        end
    end

    // A pulse is one sampled low cycle
    assign dn_low = (dn_sync == CRG_LINE_DRIVEN) && !dn_drv_d2_reg;
    assign up_low = (up_sync == CRG_LINE_DRIVEN) && !up_drv_d2_reg;

    // Exchange sequencer
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            state_reg <= CRG_IDLE;
            for_other_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                CRG_IDLE:
                begin
                    // Downstream ignored here in hold controller mode
                    if (dn_low && !hold_ctrl_mode_in)
                    begin
                        state_reg <= CRG_REQ_WAIT;
                        for_other_reg <= 1'b1;
                    end
                    else if (own_bus_req_in)
                    begin
                        state_reg <= CRG_REQ_WAIT;
                        for_other_reg <= 1'b0;
                    end
                end
                CRG_REQ_WAIT:
                begin
                    if (up_low)
                    begin
                        if (for_other_reg)
                            state_reg <= CRG_RELAY_GNT;
                        else
                            state_reg <= CRG_OWN;
                    end
                end
                CRG_RELAY_GNT:
                    state_reg <= CRG_RELAY_HELD;
                CRG_RELAY_HELD:
                begin
                    if (dn_low)
                        state_reg <= CRG_DEAD;
                end
                CRG_OWN:
                begin
                    if (own_last_cycle_done_in)
                        state_reg <= CRG_DEAD;
                    else if (dn_low)
                        state_reg <= CRG_OWN_WAIT_SLOT;
                end
                CRG_OWN_WAIT_SLOT:
                begin
                    if (final_bus_state_in || address_bus_state_in)
                        state_reg <= CRG_HANDOVER;
                end
                CRG_HANDOVER:
                begin
                    if (dn_low)
                        state_reg <= CRG_OWN;
                end
                CRG_DEAD:
                    state_reg <= CRG_IDLE;
                default:
                    state_reg <= CRG_IDLE;
            endcase
        end
    end

    // Upstream pulses: request and release, each one clock wide
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            up_oe_reg <= 1'b0;
        else
            up_oe_reg <= ((state_reg == CRG_IDLE) &&
                          ((dn_low && !hold_ctrl_mode_in) ||
                           own_bus_req_in)) ||
                         ((state_reg == CRG_RELAY_HELD) && dn_low) ||
                         ((state_reg == CRG_OWN) &&
                          own_last_cycle_done_in);
    end

    // Downstream grant: relayed after the extra pipeline clock, or own grant
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            dn_oe_reg <= 1'b0;
        else
            dn_oe_reg <= (state_reg == CRG_RELAY_GNT) ||
                         ((state_reg == CRG_OWN_WAIT_SLOT) &&
                          (final_bus_state_in ||
                           address_bus_state_in));
    end

    // Bus ownership, float and handover acknowledge
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            owned_reg <= 1'b0;
            float_reg <= 1'b0;
            ack_reg <= 1'b0;
        end
        else
        begin
            if (state_reg == CRG_REQ_WAIT && up_low && !for_other_reg)
                owned_reg <= 1'b1;
            else if (state_reg == CRG_OWN && own_last_cycle_done_in)
                owned_reg <= 1'b0;
            if (state_reg == CRG_OWN_WAIT_SLOT &&
                (final_bus_state_in || address_bus_state_in))
                float_reg <= 1'b1;
            else if (state_reg == CRG_HANDOVER && dn_low)
                float_reg <= 1'b0;
            ack_reg <= (state_reg == CRG_HANDOVER) && !dn_low;
        end
    end

    // Lines are only ever pulled low; the pull-up restores idle
    always_ff @(posedge core_clk_in)
    begin
        dn_req_grant_out <= CRG_LINE_DRIVEN;
        up_req_grant_out <= CRG_LINE_DRIVEN;
    end

    assign dn_req_grant_oe_out = dn_oe_reg;
    assign up_req_grant_oe_out = up_oe_reg;
    assign bus_owned_out = owned_reg;
    assign bus_float_out = float_reg;
    assign handover_ack_state_out = ack_reg;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    sequence s_relay_release;
        (state_reg == CRG_RELAY_HELD) && dn_low;
    endsequence

    sequence s_own_grant;
        (state_reg == CRG_OWN_WAIT_SLOT) &&
        (final_bus_state_in || address_bus_state_in);
    endsequence

    a_relay_request: assert property (
        (state_reg == CRG_IDLE) && dn_low && !hold_ctrl_mode_in
        |=> up_oe_reg ##1 !up_oe_reg)
        else $error("downstream request not relayed after one clock");
    a_grant_relay_delay: assert property (
        (state_reg == CRG_REQ_WAIT) && for_other_reg && up_low
        |=> !dn_oe_reg ##1 dn_oe_reg ##1 !dn_oe_reg)
        else $error("grant not relayed two clocks later");
    a_release_dead_clk: assert property (
        s_relay_release |=> up_oe_reg ##1 (!up_oe_reg && !dn_oe_reg))
        else $error("release not relayed or no dead clock");
    a_grant_float_ack: assert property (
        s_own_grant |=> dn_oe_reg && float_reg ##1 ack_reg && !dn_oe_reg)
        else $error("own grant not issued with float then ack");
    a_ack_follows: assert property (
        $rose(float_reg) |=> ack_reg)
        else $error("handover ack not entered after grant");
    a_reclaim_bus: assert property (
        (state_reg == CRG_HANDOVER) && dn_low
        |=> !float_reg && !ack_reg && owned_reg)
        else $error("bus not reclaimed after release");
    a_hold_mode_idle: assert property (
        (state_reg == CRG_IDLE) && hold_ctrl_mode_in && !own_bus_req_in
        |=> !up_oe_reg)
        else $error("downstream used while not owner in hold mode");
    a_own_grant_use: assert property (
        (state_reg == CRG_REQ_WAIT) && !for_other_reg && up_low
        |=> owned_reg)
        else $error("bus use not started after own grant");
    a_own_release: assert property (
        (state_reg == CRG_OWN) && own_last_cycle_done_in
        |=> up_oe_reg && !owned_reg)
        else $error("release not sent after last own cycle");
    a_pulse_width: assert property (
        up_oe_reg || dn_oe_reg |=> !(up_oe_reg && $past(up_oe_reg)) &&
        !(dn_oe_reg && $past(dn_oe_reg)))
        else $error("request/grant pulse longer than one clock");
endmodule

// ### crg_partner.sv
// Far-side model: host CPU on the upstream line, second master downstream.
// Assumes active-low lines with pull-ups, resolved by the bench.
`timescale 1ns/1ns
module crg_partner (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic up_line_in,
    input wire logic dn_line_in,
    input wire logic start_in,
    input wire logic [3:0] dly_in,
    output logic cpu_pull_out,
    output logic mst_pull_out,
    output logic busy_out
);
    logic [1:0] cpu_reg;
    logic [1:0] mst_reg;
    logic [3:0] cpu_cnt_reg;
    logic [3:0] mst_cnt_reg;
    // A party never takes its own pull for the other side's pulse
    wire up_seen = !up_line_in && !cpu_pull_out;
    wire dn_seen = !dn_line_in && !mst_pull_out;
    assign busy_out = (cpu_reg != 2'h0) || (mst_reg != 2'h0);
    always @(posedge clk_in)
    begin
        cpu_pull_out <= 1'b0;
        if (rst_in)
            cpu_reg <= 2'h0;
        else if (cpu_reg == 2'h0 && up_seen)
        begin
            cpu_reg <= 2'h1;
            cpu_cnt_reg <= dly_in;
        end
        else if (cpu_reg == 2'h1)
        begin
            cpu_cnt_reg <= cpu_cnt_reg - 4'h1;
            if (cpu_cnt_reg == 4'h0)
            begin
                cpu_pull_out <= 1'b1;
                cpu_reg <= 2'h2;
            end
        end
        else if (cpu_reg == 2'h2 && up_seen)
            cpu_reg <= 2'h0;
    end
    always @(posedge clk_in)
    begin
        mst_pull_out <= 1'b0;
        if (rst_in)
            mst_reg <= 2'h0;
        else if (mst_reg == 2'h0 && start_in)
        begin
            mst_pull_out <= 1'b1;
            mst_reg <= 2'h1;
        end
        else if (mst_reg == 2'h1 && dn_seen)
        begin
            mst_reg <= 2'h2;
            mst_cnt_reg <= dly_in;
        end
        else if (mst_reg == 2'h2)
        begin
            mst_cnt_reg <= mst_cnt_reg - 4'h1;
            if (mst_cnt_reg == 4'h0)
            begin
                mst_pull_out <= 1'b1;
                mst_reg <= 2'h0;
            end
        end
    end
endmodule

// ### crg_relay_tb.sv
// Bench for the request/grant relay: random relayed and owned exchanges.
// Assumes the far-side model; open-drain lines are resolved here.
`timescale 1ns/1ns
module crg_relay_tb;
    logic clk, srst, own_req, done, fin, adr, hold, start, tb_pull;
    logic up_oe, dn_oe, up_out, dn_out, owned, flt, ack, cpu_pull;
    logic mst_pull, busy, pu, pd, pw, pown, pack, pfl, sel;
    logic [3:0] dly;
    int seed = 32'h45acebf4;
    int cyc, t_o, t_w, t_own, t_ack, t_ff, t_done, error_cnt, num_checks;
    int q_m[$], q_c[$], q_u[$], q_d[$];
    // Pull-ups hold both lines high whenever nobody pulls
    wire dn_line = (dn_oe ? dn_out : 1'b1) & !mst_pull & !tb_pull;
    wire up_line = (up_oe ? up_out : 1'b1) & !cpu_pull;
    crg_relay dut (.core_clk_in(clk), .srst_in(srst),
        .dn_req_grant_in(dn_line), .dn_req_grant_out(dn_out),
        .dn_req_grant_oe_out(dn_oe), .up_req_grant_in(up_line),
        .up_req_grant_out(up_out), .up_req_grant_oe_out(up_oe),
        .own_bus_req_in(own_req), .own_last_cycle_done_in(done),
        .final_bus_state_in(fin), .address_bus_state_in(adr),
        .hold_ctrl_mode_in(hold), .bus_owned_out(owned),
        .bus_float_out(flt), .handover_ack_state_out(ack));
    crg_partner far (.clk_in(clk), .rst_in(srst), .up_line_in(up_line),
        .dn_line_in(dn_line), .start_in(start), .dly_in(dly),
        .cpu_pull_out(cpu_pull), .mst_pull_out(mst_pull), .busy_out(busy));
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Event log: each entry is the edge that first saw the pulse
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 20000)
            error_cnt++;
        if (cyc > 20000)
            end_sim();
        if (mst_pull) q_m.push_back(cyc);
        if (cpu_pull) q_c.push_back(cyc);
        if (up_oe) q_u.push_back(cyc);
        if (dn_oe) q_d.push_back(cyc);
        if (own_req) t_o = cyc;
        if (done) t_done = cyc;
        if ((fin | adr) && !pw) t_w = cyc;
        if (owned && !pown) t_own = cyc;
        if (ack && !pack) t_ack = cyc;
        if (!flt && pfl) t_ff = cyc;
        if (pu | pd)
            chk("oe_width", 2'h0, {up_oe & pu, dn_oe & pd});
        {pu, pd, pw, pown, pack, pfl} = {up_oe, dn_oe, fin | adr, owned,
            ack, flt};
    end
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic cond(int w);
        case (w)
            0: return !busy;
            1: return owned === 1'b1;
            2: return q_d.size() > 0;
            default: return flt === 1'b0;
        endcase
    endfunction
    task automatic wait_on(int w);
        for (int k = 0; k < 300 && !cond(w); k++)
            tick(1);
        // A wait that runs out is a hung exchange
        chk("wait_done", 1, cond(w));
    endtask
    task automatic begin_ex;
        q_m = {};
        q_c = {};
        q_u = {};
        q_d = {};
        dly = 4'($random(seed));
    endtask
    task automatic relay;
        begin_ex();
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(2);
        wait_on(0);
        tick(3);
        chk("relay_req", 3, q_u[0] - q_m[0]);
        chk("relay_gnt", 4, q_d[0] - q_c[0]);
        chk("relay_rel", 3, q_u[1] - q_m[1]);
        chk("pulse_cnt", 3, q_u.size() + q_c.size());
    endtask
    task automatic own;
        begin_ex();
        // Alternate so both bus states open the grant slot
        sel = !sel;
        hold = 1'($random(seed));
        own_req = 1'b1;
        tick(1);
        own_req = 1'b0;
        wait_on(1);
        // The event log stamps a rise one edge after it is visible
        tick(1);
        chk("own_req", 1, q_u[0] - t_o);
        chk("own_start", 3, t_own - q_c[0]);
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(6);
        chk("no_slot", 0, q_d.size());
        fin = sel;
        adr = !sel;
        wait_on(2);
        fin = 1'b0;
        adr = 1'b0;
        chk("grant_slot", 1, q_d[0] - t_w);
        chk("floated", 1, flt);
        tick(1);
        chk("ack_delay", 1, t_ack - q_d[0]);
        done = 1'b1;
        tick(1);
        done = 1'b0;
        wait_on(3);
        tick(1);
        chk("release", 3, t_ff - q_m[1]);
        chk("reclaim", 2'h1, {ack, owned});
        chk("ack_done_off", 1, q_u.size());
        tick(2);
        done = 1'b1;
        tick(1);
        done = 1'b0;
        wait_on(0);
        tick(3);
        chk("own_rel", 1, q_u[1] - t_done);
        chk("own_end", 0, owned);
    endtask
    initial
    begin
        {srst, own_req, done, fin, adr, hold, start, tb_pull} = 8'h80;
        {pu, pd, pw, pown, pack, pfl} = 6'h0;
        dly = 4'h0;
        sel = 1'b0;
        tick(8);
        chk("reset_out", 6'h0, {up_oe, dn_oe, owned, flt, ack,
            up_out | dn_out});
        srst = 1'b0;
        tick(12);
        chk("idle_line", 0, q_u.size());
        hold = 1'b1;
        tb_pull = 1'b1;
        tick(1);
        tb_pull = 1'b0;
        tick(8);
        chk("hold_ignore", 0, q_u.size());
        hold = 1'b0;
        repeat (6) relay();
        repeat (4) own();
        end_sim();
    end
endmodule
